// File: hw/pwr_monitor.sv
// Digital control of a current and power monitor: APB registers,
// strap address decode, I2C address acknowledge, conversion sequencing.
// Assumes strap codes and sampled converter words arrive from pads/analog.
//
// How it works
// - Sixteen target addresses from two four-way straps.
// - Address is 100, high code, low code.
// - Triggered mode converts once per mode write.
// - Continuous mode restarts right after completion.
// - Power-down converts nothing, registers still work.
// - Mode selects shunt, bus or both.
// - Averaging stores only the mean result.
// - Conversion time setting sets each conversion length.
// - Alert is active low after reset.
// - Conversion-ready raises alert when enabled.
module pwr_monitor #(
  parameter int W = 16
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps and I2C pins
  input wire logic [1:0] addr_select_low_pin,
  input wire logic [1:0] addr_select_high_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Converter samples and alert
  input wire logic [W-1:0] shunt_sample,
  input wire logic [W-1:0] bus_sample,
  output logic alert_pin
);
  initial begin
    if (W < 4 || W > 24) $error("pwr_monitor: W out of range");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [8:0] cfg_reg;
  logic [2:0] actl_reg;
  logic [15:0] limit_reg;
  logic cnvr_reg;
  logic start_reg;
  logic pend_s_reg, pend_b_reg;
  logic [W-1:0] sh_res, bu_res;
  logic sh_done, bu_done, sh_busy, bu_busy;
  logic [2:0] mode;
  logic setup, access, wr_acc, cfg_wr, stat_rd, mapped, over, active, all_done;
  logic pend_s_next, pend_b_next;
  logic [6:0] my_addr;

  assign mode = cfg_reg[pwrmon_pkg::CFG_MODE_LSB +: 3];
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_acc = access && pwrite && !pslverr;
  assign cfg_wr = wr_acc && paddr == pwrmon_pkg::OFS_CONFIG;
  assign stat_rd = access && !pwrite && paddr == pwrmon_pkg::OFS_STATUS;
  assign mapped = paddr == pwrmon_pkg::OFS_CONFIG || paddr == pwrmon_pkg::OFS_SHUNT_RESULT
    || paddr == pwrmon_pkg::OFS_BUS_RESULT || paddr == pwrmon_pkg::OFS_ALERT_CTRL
    || paddr == pwrmon_pkg::OFS_LIMIT || paddr == pwrmon_pkg::OFS_STATUS;

  // Zero wait states: the answer stands in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        case (paddr)
          pwrmon_pkg::OFS_CONFIG: prdata <= 32'(cfg_reg);
          pwrmon_pkg::OFS_SHUNT_RESULT: prdata <= 32'(sh_res);
          pwrmon_pkg::OFS_BUS_RESULT: prdata <= 32'(bu_res);
          pwrmon_pkg::OFS_ALERT_CTRL: prdata <= 32'(actl_reg);
          pwrmon_pkg::OFS_LIMIT: prdata <= 32'(limit_reg);
          pwrmon_pkg::OFS_STATUS: prdata <= 32'({my_addr, pend_s_reg | pend_b_reg, active,
            cnvr_reg});
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= pwrmon_pkg::CFG_RESET;
      actl_reg <= pwrmon_pkg::ACTL_RESET;
      limit_reg <= pwrmon_pkg::LIMIT_RESET;
    end else if (wr_acc) begin
      case (paddr)
        pwrmon_pkg::OFS_CONFIG: cfg_reg <= pwdata[8:0];
        pwrmon_pkg::OFS_ALERT_CTRL: actl_reg <= pwdata[2:0];
        pwrmon_pkg::OFS_LIMIT: limit_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Conversion sequencing
  // ****************************************
  // A mode write outranks a start in the same cycle: the channels are aborted
  // then, so nothing may stay marked pending that can never complete.
  assign pend_s_next = cfg_wr ? 1'b0 : start_reg ? mode[pwrmon_pkg::MODE_SHUNT_BIT]
    : (pend_s_reg && !sh_done);
  assign pend_b_next = cfg_wr ? 1'b0 : start_reg ? mode[pwrmon_pkg::MODE_BUS_BIT]
    : (pend_b_reg && !bu_done);
  assign all_done = (pend_s_reg || pend_b_reg) && !pend_s_next && !pend_b_next && !cfg_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      pend_s_reg <= 1'b0;
      pend_b_reg <= 1'b0;
    end else begin
      // A select of zero is power-down: no start is ever issued.
      if (cfg_wr) begin
        start_reg <= pwdata[1:0] != 2'b00;
      end else begin
        start_reg <= all_done && mode[pwrmon_pkg::MODE_CONT_BIT];
      end
      pend_s_reg <= pend_s_next;
      pend_b_reg <= pend_b_next;
    end
  end

  logic [15:0] conv_cycles;
  assign conv_cycles = 16'(pwrmon_pkg::CONV_BASE_CYC) << cfg_reg[pwrmon_pkg::CFG_CT_LSB +: 3];

  conv_channel #(.W(W)) u_shunt (
    .pclk(pclk), .presetn(presetn),
    .start(start_reg && mode[pwrmon_pkg::MODE_SHUNT_BIT] && !cfg_wr), .abort(cfg_wr),
    .conv_cycles(conv_cycles), .avg_shift(cfg_reg[pwrmon_pkg::CFG_AVG_LSB +: 3]),
    .sample(shunt_sample), .result(sh_res), .done(sh_done), .busy(sh_busy)
  );
  conv_channel #(.W(W)) u_bus (
    .pclk(pclk), .presetn(presetn),
    .start(start_reg && mode[pwrmon_pkg::MODE_BUS_BIT] && !cfg_wr), .abort(cfg_wr),
    .conv_cycles(conv_cycles), .avg_shift(cfg_reg[pwrmon_pkg::CFG_AVG_LSB +: 3]),
    .sample(bus_sample), .result(bu_res), .done(bu_done), .busy(bu_busy)
  );

  // ****************************************
  // Alert
  // ****************************************
  assign over = actl_reg[pwrmon_pkg::ACTL_LIMIT_EN] && 24'(bu_res) > 24'(limit_reg);
  assign active = over || (actl_reg[pwrmon_pkg::ACTL_CNVR_EN] && cnvr_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnvr_reg <= 1'b0;
      alert_pin <= 1'b1;
    end else begin
      // A completion in the clearing read's cycle wins over the clear.
      cnvr_reg <= all_done || (cnvr_reg && !stat_rd);
      alert_pin <= active ~^ actl_reg[pwrmon_pkg::ACTL_POL];
    end
  end

  // ****************************************
  // Strap address and I2C acknowledge
  // ****************************************
  logic [3:0] strap_s1, strap_s2;
  logic [1:0] strap_cnt;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt;
  pwrmon_pkg::i2c_state_t i_state;

  // Straps are caught once, after two synchroniser stages settle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
      strap_cnt <= 2'h0;
      my_addr <= 7'h00;
    end else begin
      strap_s1 <= {addr_select_high_pin, addr_select_low_pin};
      strap_s2 <= strap_s1;
      if (strap_cnt != 2'h3) begin
        strap_cnt <= strap_cnt + 2'h1;
        if (strap_cnt == 2'h2) begin
          my_addr <= {pwrmon_pkg::ADDR_PREFIX, strap_s2};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_s1, scl_s2, scl_d} <= 3'b111;
      {sda_s1, sda_s2, sda_d} <= 3'b111;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_state <= pwrmon_pkg::I_IDLE;
      shift_reg <= 8'h00;
      bit_cnt <= 3'h0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (scl_s2 && sda_d && !sda_s2) begin
      i_state <= pwrmon_pkg::I_ADDR;
      bit_cnt <= 3'h0;
      sda_oe <= 1'b0;
    end else if (scl_s2 && !sda_d && sda_s2) begin
      i_state <= pwrmon_pkg::I_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (i_state)
        pwrmon_pkg::I_ADDR: begin
          if (scl_s2 && !scl_d) begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              i_state <= pwrmon_pkg::I_DEC;
            end
          end
        end
        pwrmon_pkg::I_DEC: begin
          if (!scl_s2 && scl_d) begin
            // Foreign addresses never see the data line driven.
            if (shift_reg[7:1] == my_addr) begin
              sda_oe <= 1'b1;
              i_state <= pwrmon_pkg::I_ACK;
            end else begin
              i_state <= pwrmon_pkg::I_SKIP;
            end
          end
        end
        pwrmon_pkg::I_ACK: begin
          if (!scl_s2 && scl_d) begin
            sda_oe <= 1'b0;
            i_state <= pwrmon_pkg::I_SKIP;
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_addr_form;
    strap_cnt == 2'h3 |=> my_addr[6:4] == 3'b100 && $stable(my_addr);
  endproperty
  a_addr_form: assert property (p_addr_form) else $error("bad target address");
  property p_addr_range;
    strap_cnt == 2'h3 |-> my_addr >= 7'h40 && my_addr <= 7'h4F;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address outside range");
  property p_trig_start;
    $rose(start_reg) |-> $past(cfg_wr) || mode[pwrmon_pkg::MODE_CONT_BIT];
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("unrequested start");
  property p_cont_restart;
    all_done && mode[pwrmon_pkg::MODE_CONT_BIT] |=> start_reg ##1
      (pend_s_reg || pend_b_reg || $past(cfg_wr));
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("no restart");
  property p_pdown;
    mode[1:0] == 2'b00 && !start_reg |=> !pend_s_reg && !pend_b_reg;
  endproperty
  a_pdown: assert property (p_pdown) else $error("conversion in power-down");
  property p_select;
    sh_busy |-> mode[pwrmon_pkg::MODE_SHUNT_BIT] || $past(cfg_wr);
  endproperty
  a_select: assert property (p_select) else $error("shunt converts unselected");
  property p_alert_pol;
    !actl_reg[pwrmon_pkg::ACTL_POL] && !active |=> alert_pin;
  endproperty
  a_alert_pol: assert property (p_alert_pol) else $error("idle alert not high");
  property p_cnvr_alert;
    all_done && actl_reg == 3'b010 && !wr_acc |=> ##1 !alert_pin;
  endproperty
  a_cnvr_alert: assert property (p_cnvr_alert) else $error("no ready alert");
  property p_ack_own;
    $rose(sda_oe) |-> $past(shift_reg[7:1]) == my_addr ##1 sda_oe;
  endproperty
  a_ack_own: assert property (p_ack_own) else $error("foreign address acked");
  c_ack: cover property ($rose(sda_oe));
  c_cont: cover property (all_done ##1 start_reg);
  c_alert: cover property ($fell(alert_pin));
endmodule

// File: hw/pwrmon_pkg.sv
// Constants shared by the power monitor control logic.
// Assumes a 25 MHz pclk and a 32-bit APB register port.
package pwrmon_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int CONV_BASE_NS = 1000;
  localparam int CONV_BASE_CYC = (CONV_BASE_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SHUNT_RESULT = 8'h04;
  localparam logic [7:0] OFS_BUS_RESULT = 8'h08;
  localparam logic [7:0] OFS_ALERT_CTRL = 8'h0C;
  localparam logic [7:0] OFS_LIMIT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_AVG_LSB = 3;
  localparam int CFG_CT_LSB = 6;
  localparam int CFG_W = 9;
  localparam logic [8:0] CFG_RESET = 9'h007;
  localparam int MODE_SHUNT_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_CONT_BIT = 2;
  localparam int ACTL_LIMIT_EN = 0;
  localparam int ACTL_CNVR_EN = 1;
  localparam int ACTL_POL = 2;
  localparam logic [2:0] ACTL_RESET = 3'h0;
  localparam int STAT_CNVR = 0;
  localparam int STAT_ALERT = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_ADDR_LSB = 3;
  localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
  // ****************************************
  // Target address
  // ****************************************
  localparam logic [2:0] ADDR_PREFIX = 3'h4;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_SUPPLY = 2'h1;
  localparam logic [1:0] STRAP_DATA = 2'h2;
  localparam logic [1:0] STRAP_CLOCK = 2'h3;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_DEC, I_ACK, I_SKIP} i2c_state_t;
endpackage

// File: hw/conv_channel.sv
// One measurement channel: times conversions and averages samples.
// Assumes the sample input is a settled converter word on pclk.
module conv_channel #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] conv_cycles,
  input wire logic [2:0] avg_shift,
  input wire logic [W-1:0] sample,
  // Result
  output logic [W-1:0] result,
  output logic done,
  output logic busy
);
  initial begin
    if (W < 4 || W > 24) $error("conv_channel: W out of range");
  end

  logic [15:0] timer_reg;
  logic [7:0] count_reg;
  logic [W+7:0] acc_reg;
  logic [W+7:0] sum;
  logic tick;

  assign tick = busy && (timer_reg == conv_cycles - 16'h0001);
  assign sum = acc_reg + {8'h00, sample};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      timer_reg <= 16'h0000;
      count_reg <= 8'h00;
      acc_reg <= '0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        timer_reg <= 16'h0000;
        count_reg <= 8'h00;
        acc_reg <= '0;
      end else if (abort) begin
        busy <= 1'b0;
      end else if (tick) begin
        timer_reg <= 16'h0000;
        // Only the mean reaches the result, after 2^avg samples.
        if (count_reg == 8'((9'h001 << avg_shift) - 9'h001)) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= W'(sum >> avg_shift);
        end else begin
          acc_reg <= sum;
          count_reg <= count_reg + 8'h01;
        end
      end else if (busy) begin
        timer_reg <= timer_reg + 16'h0001;
      end
    end
  end

  property p_done_after_busy;
    @(posedge pclk) disable iff (!presetn) done |-> $past(busy) && !busy;
  endproperty
  a_done_after_busy: assert property (p_done_after_busy) else $error("done without busy");
  property p_tick_spacing;
    @(posedge pclk) disable iff (!presetn)
      tick && !start && !abort |=> timer_reg == 16'h0000;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("timer not restarted");
  c_avg_done: cover property (@(posedge pclk) done && avg_shift != 3'h0);
endmodule

// File: tb/i2c_host_model.sv
// I2C host that sends one address byte and reports whether it was acknowledged.
// Assumes an open-drain SDA wire with pull-up resolved by the bench.
module i2c_host_model (
  // Clock
  input wire logic pclk,
  // Bus lines
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv_low
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 10;
  initial begin
    scl = 1'b1;
    sda_drv_low = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(posedge pclk);
  endtask
  // SDA only moves a few cycles after SCL falls, so no false START is seen.
  task automatic hold();
    repeat (3) @(posedge pclk);
  endtask
  task automatic send_addr(input logic [6:0] a, output logic ack);
    logic [7:0] b;
    b = {a, 1'b0};
    sda_drv_low <= 1'b1;
    tick();
    for (int i = 7; i >= 0; i--) begin
      scl <= 1'b0;
      hold();
      sda_drv_low <= ~b[i];
      tick();
      scl <= 1'b1;
      tick();
    end
    scl <= 1'b0;
    hold();
    sda_drv_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    ack = (sda_wire === 1'b0);
    scl <= 1'b0;
    hold();
    sda_drv_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_drv_low <= 1'b0;
    tick();
  endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the power monitor: APB tasks and I2C address probes.
// Assumes a zero-wait APB slave and the host model on the SDA and SCL lines.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, sda_out, sda_oe, alert_pin, scl, host_low, sda_wire;
  logic [1:0] lo_pin = 2'h0;
  logic [1:0] hi_pin = 2'h0;
  logic [15:0] shunt_s = 16'h0000;
  logic [15:0] bus_s = 16'h0000;
  int n_fail = 0;
  int n_tests = 0;
  always #20 pclk = ~pclk;
  assign sda_wire = !host_low && !(sda_oe && !sda_out);
  pwr_monitor pwr_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_select_low_pin(lo_pin), .addr_select_high_pin(hi_pin), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .shunt_sample(shunt_s), .bus_sample(bus_s), .alert_pin(alert_pin));
  i2c_host_model i2c_host_model_inst (.pclk(pclk), .sda_wire(sda_wire), .scl(scl),
    .sda_drv_low(host_low));
  // ****************************************
  // Tasks
  // ****************************************
  task complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] d, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask
  task do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask
  // Clears the sticky ready flag first, then counts cycles to the alert edge.
  task wait_alert(input logic [31:0] cfg, output int cnt);
    logic [31:0] d;
    rd(pwrmon_pkg::OFS_STATUS, d);
    wr(pwrmon_pkg::OFS_CONFIG, cfg);
    cnt = 0;
    while (alert_pin !== 1'b0) begin
      @(posedge pclk);
      cnt++;
    end
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    logic e, ack;
    logic [6:0] ad;
    int cnt, n, ct, av;
    static int tct[4] = '{0, 1, 0, 1};
    static int tav[4] = '{0, 0, 1, 2};
    for (int k = 0; k < 16; k++) begin
      lo_pin <= 2'(k);
      hi_pin <= 2'(k >> 2);
      do_reset();
      ad = {3'h4, 2'(k >> 2), 2'(k)};
      rd(pwrmon_pkg::OFS_STATUS, d);
      check(32'(d[9:3]), 32'(ad));
      i2c_host_model_inst.send_addr(ad, ack);
      check(32'(ack), 32'h0000_0001);
      i2c_host_model_inst.send_addr(ad ^ 7'h01, ack);
      check(32'(ack), 32'h0000_0000);
    end
    check(32'(alert_pin), 32'h0000_0001);
    rd(pwrmon_pkg::OFS_CONFIG, d);
    check(d, 32'h0000_0007);
    rd(pwrmon_pkg::OFS_LIMIT, d);
    check(d, 32'h0000_FFFF);
    apb(1'b0, 8'h18, 32'h0000_0000, d, e);
    check({d[30:0], e}, 32'h0000_0001);
    wr(pwrmon_pkg::OFS_ALERT_CTRL, 32'h0000_0002);
    for (int t = 0; t < 4; t++) begin
      ct = tct[t];
      av = tav[t];
      n = (25 << ct) << av;
      shunt_s <= 16'h0100;
      bus_s <= 16'h1000;
      wait_alert(32'(ct << 6) | 32'(av << 3) | 32'h0000_0003, cnt);
      check(32'(cnt >= n && cnt <= n + 8), 32'h0000_0001);
      rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
      check(d, 32'h0000_0100);
      shunt_s <= 16'h0300;
      wait_alert(32'(ct << 6) | 32'(av << 3) | 32'h0000_0003, cnt);
      rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
      check(d, 32'h0000_0300);
    end
    // Four samples of 50 cycles; the word steps up between the second and third,
    // so only a true mean of all four gives 0x300.
    shunt_s <= 16'h0100;
    rd(pwrmon_pkg::OFS_STATUS, d);
    wr(pwrmon_pkg::OFS_CONFIG, 32'h0000_0053);
    repeat (125) @(posedge pclk);
    shunt_s <= 16'h0500;
    while (alert_pin !== 1'b0) @(posedge pclk);
    rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
    check(d, 32'h0000_0300);
    shunt_s <= 16'h0100;
    bus_s <= 16'h2000;
    wait_alert(32'h0000_0043, cnt);
    repeat (130) @(posedge pclk);
    shunt_s <= 16'h0500;
    repeat (300) @(posedge pclk);
    rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
    check(d, 32'h0000_0100);
    rd(pwrmon_pkg::OFS_STATUS, d);
    check(32'(d[2]), 32'h0000_0000);
    wait_alert(32'h0000_0001, cnt);
    rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
    check(d, 32'h0000_0500);
    rd(pwrmon_pkg::OFS_BUS_RESULT, d);
    check(d, 32'h0000_2000);
    bus_s <= 16'h0600;
    shunt_s <= 16'h0700;
    wait_alert(32'h0000_0002, cnt);
    rd(pwrmon_pkg::OFS_BUS_RESULT, d);
    check(d, 32'h0000_0600);
    rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
    check(d, 32'h0000_0500);
    wr(pwrmon_pkg::OFS_CONFIG, 32'h0000_0007);
    repeat (80) @(posedge pclk);
    rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
    check(d, 32'h0000_0700);
    shunt_s <= 16'h0800;
    repeat (80) @(posedge pclk);
    rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
    check(d, 32'h0000_0800);
    wr(pwrmon_pkg::OFS_CONFIG, 32'h0000_0004);
    shunt_s <= 16'h0900;
    repeat (200) @(posedge pclk);
    rd(pwrmon_pkg::OFS_SHUNT_RESULT, d);
    check(d, 32'h0000_0800);
    wr(pwrmon_pkg::OFS_LIMIT, 32'h0000_0100);
    rd(pwrmon_pkg::OFS_LIMIT, d);
    check(d, 32'h0000_0100);
    wr(pwrmon_pkg::OFS_ALERT_CTRL, 32'h0000_0001);
    bus_s <= 16'h2000;
    wait_alert(32'h0000_0003, cnt);
    check(32'(alert_pin), 32'h0000_0000);
    wr(pwrmon_pkg::OFS_ALERT_CTRL, 32'h0000_0005);
    repeat (4) @(posedge pclk);
    check(32'(alert_pin), 32'h0000_0001);
    complete_run();
  end
endmodule
